// ### hdl/phy_regs_cfg.svh
`ifndef PHY_REGS_CFG_SVH
`define PHY_REGS_CFG_SVH

// register offsets on the management port (5-bit register index)
`define OFS_TRANSCEIVER_CONTROL 5'h10
`define OFS_LINK_STATUS_SUMMARY 5'h11

// control field positions
`define CTL_TX_FIFO_HI      15
`define CTL_TX_FIFO_LO      14
`define CTL_FORCE_LINK      10
`define CTL_PSAVE_HI        9
`define CTL_PSAVE_LO        8
`define CTL_DEEP_PD         7
`define CTL_SWAP_HI         6
`define CTL_SWAP_LO         5
`define CTL_CLK_OFF         4
`define CTL_RSVD_ONE        3
`define CTL_STANDBY         2
`define CTL_TX_INV          1
`define CTL_JABBER_OFF      0

// control reset values
`define CTL_TX_FIFO_RST     2'b01
`define CTL_RSVD_HI_VAL     3'b010
`define CTL_SWAP_RST        2'b10

// status reset values
`define STS_POL_RST         1'b1

// active sleep wake pulse period
`define WAKE_PULSE_MS       1400
`define CLK_KHZ             25000

`endif

// ### hdl/phy_regs_pkg.sv
package phy_regs_pkg;

    // crossover selection
    typedef enum logic [1:0] {
        SWAP_MDI  = 2'b00,
        SWAP_MDIX = 2'b01,
        SWAP_AUTO = 2'b10
    } swap_mode_t;

    // power save selection
    typedef enum logic [1:0] {
        PS_NORMAL  = 2'b00,
        PS_IEEE_PD = 2'b01,
        PS_ACTIVE  = 2'b10,
        PS_PASSIVE = 2'b11
    } psave_t;

    // resolved line rate encoding
    typedef enum logic [1:0] {
        RATE_10   = 2'b00,
        RATE_100  = 2'b01,
        RATE_1000 = 2'b10
    } rate_t;

endpackage

// ### hdl/phy_control_status_regs.sv
// Overview of operation
// - crossover field: 1x auto, 01 MDI-X, 00 MDI
// - bit 4 stops the 125 MHz clock
// - bit 3 reserved, reads one, writes ignored
// - bit 2 standby blocks link, keeps power
// - bit 1 inverts transmit line driver
// - bit 0 disables jabber detection
// - bits 15:14 report resolved line rate
// - bit 13 reports full duplex
// - bit 12 latches page received, read clears
// - bit 11 set when negotiation done or off
// - bit 10 mirrors current link state
// - bits 9:8 report CD and AB crossover
// - bit 7 shows speed optimization during negotiation
// - bit 6 shows sleep state
// - bits 5:2 give gigabit channel polarity D..A
// - bit 1 gives 10M polarity, resets one
// - bit 0 mirrors jabber, read never clears
// - IEEE power-down with clock enabled stops PLL
// - power save: normal, IEEE, active, passive sleep
//
// The strobed register port was chosen for this implementation.
`include "phy_regs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module phy_control_status_regs #(
    parameter int WAKE_CYCLES = `WAKE_PULSE_MS * `CLK_KHZ  // active sleep pulse period
) (
    input  wire logic        clk,                 // 25 MHz device clock
    input  wire logic        rstn,                // synchronous reset, active low
    input  wire logic [4:0]  reg_addr,            // register index
    input  wire logic [15:0] reg_wdata,           // write data
    input  wire logic        reg_wr,              // write strobe
    input  wire logic        reg_rd,              // read strobe
    output logic      [15:0] reg_rdata,           // read data, cycle after strobe
    input  wire logic [1:0]  strap_swap,          // crossover strap sampled after reset
    input  wire logic [1:0]  st_rate,             // resolved rate from core
    input  wire logic        st_full_duplex,      // full duplex from core
    input  wire logic        st_page_rx,          // page received event
    input  wire logic        st_an_enable,        // negotiation enabled
    input  wire logic        st_an_done,          // negotiation complete
    input  wire logic        st_link_up,          // raw link state
    input  wire logic        st_cd_swapped,       // pairs cd resolved mdix
    input  wire logic        st_ab_swapped,       // pairs ab resolved mdix
    input  wire logic        st_downshift,        // speed optimization active
    input  wire logic        st_sleeping,         // sleep state
    input  wire logic [3:0]  st_chan_pol,         // channel polarity d,c,b,a
    input  wire logic        st_pol_10m,          // 10M polarity good
    input  wire logic        st_jabber,           // jabber detected
    input  wire logic        partner_seen,        // energy from link partner
    output logic             gigabit_ref_clock_out_en, // 125 MHz clock enable
    output logic             pll_power_down,      // pll off request
    output logic             analog_power_down,   // digital and analog off
    output logic             link_block,          // blocks link bring-up
    output logic             tx_invert_enable,    // invert line driver
    output logic             jabber_enable,       // jabber detection on
    output logic [1:0]       pair_swap_select,    // crossover mode to pma
    output logic             force_link_good,     // force link good
    output logic [1:0]       tx_fifo_depth,       // transmit fifo depth
    output logic             deep_power_down_en,  // deep power-down enable
    output logic             wake_pulse           // link pulse in active sleep
);

    localparam int CNT_W = $clog2(WAKE_CYCLES + 1);

    // two-stage synchronisers for the pin and core inputs
    logic [22:0] sync1_reg;                        // first stage
    logic [22:0] sync2_reg;                        // second stage
    logic [1:0]  strap_s1_reg;                     // strap first stage
    logic [1:0]  strap_s2_reg;                     // strap second stage

    // control fields
    logic [1:0]  fifo_reg;                         // tx fifo depth
    logic        force_reg;                        // force link good
    logic [1:0]  psave_reg;                        // power save mode
    logic        deep_reg;                         // deep power-down
    logic [1:0]  swap_reg;                         // crossover selection
    logic        clk_off_reg;                      // 125 MHz clock disable
    logic        standby_reg;                      // standby
    logic        inv_reg;                          // line driver inversion
    logic        jab_off_reg;                      // jabber disable
    logic        strap_done_reg;                   // strap already captured

    // status state
    logic        page_reg;                         // latched page received
    logic        page_prev_reg;                    // page event edge detect
    logic        sleeping_reg;                     // active sleep engaged, or passive sleep selected
    logic [CNT_W-1:0] wake_cnt_reg;                // pulse period counter

    // synchronised views
    logic [1:0] s_rate;
    logic       s_fdx, s_page, s_an_en, s_an_done, s_link, s_cd, s_ab;
    logic       s_ds, s_sleep, s_pol10, s_jab, s_partner;
    logic [3:0] s_pol;
    logic [1:0] s_strap;
    logic       page_evt;
    logic       wr_ctl, wr_sts_rd;
    logic [15:0] ctl_word, sts_word;

    // decode of the management address
    function automatic logic addr_hit(input logic [4:0] a, input logic [4:0] ofs);
        addr_hit = (a == ofs);
    endfunction

    // stage one and two of every asynchronous input except the crossover strap
    // the 10M polarity stage resets to one so the status bit reads one from reset
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sync1_reg    <= 23'h00_0080;
            sync2_reg    <= 23'h00_0080;
        end else begin
            sync1_reg    <= {st_rate, st_full_duplex, st_page_rx, st_an_enable, st_an_done,
                             st_link_up, st_cd_swapped, st_ab_swapped, st_downshift,
                             st_sleeping, st_chan_pol, st_pol_10m, st_jabber,
                             partner_seen, 5'h00};
            sync2_reg    <= sync1_reg;
        end
    end

    // strap stages run through reset so the level is settled when it is captured
    always_ff @(posedge clk) begin
        strap_s1_reg <= strap_swap;
        strap_s2_reg <= strap_s1_reg;
    end

    assign {s_rate, s_fdx, s_page, s_an_en, s_an_done, s_link, s_cd, s_ab, s_ds,
            s_sleep, s_pol, s_pol10, s_jab, s_partner} = sync2_reg[22:5];
    assign s_strap   = strap_s2_reg;
    assign page_evt  = s_page & ~page_prev_reg;
    assign wr_ctl    = reg_wr & addr_hit(reg_addr, `OFS_TRANSCEIVER_CONTROL);
    assign wr_sts_rd = reg_rd & addr_hit(reg_addr, `OFS_LINK_STATUS_SUMMARY);

    // control register writes; status writes fall through unused
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fifo_reg       <= `CTL_TX_FIFO_RST;
            force_reg      <= 1'b0;
            psave_reg      <= 2'h0;
            deep_reg       <= 1'b0;
            swap_reg       <= `CTL_SWAP_RST;
            clk_off_reg    <= 1'b0;
            standby_reg    <= 1'b0;
            inv_reg        <= 1'b0;
            jab_off_reg    <= 1'b0;
            strap_done_reg <= 1'b0;
        end else if (wr_ctl) begin
            // bit 3 and 13:11 are not stored
            fifo_reg       <= reg_wdata[`CTL_TX_FIFO_HI:`CTL_TX_FIFO_LO];
            force_reg      <= reg_wdata[`CTL_FORCE_LINK];
            psave_reg      <= reg_wdata[`CTL_PSAVE_HI:`CTL_PSAVE_LO];
            deep_reg       <= reg_wdata[`CTL_DEEP_PD];
            swap_reg       <= reg_wdata[`CTL_SWAP_HI:`CTL_SWAP_LO];
            clk_off_reg    <= reg_wdata[`CTL_CLK_OFF];
            standby_reg    <= reg_wdata[`CTL_STANDBY];
            inv_reg        <= reg_wdata[`CTL_TX_INV];
            jab_off_reg    <= reg_wdata[`CTL_JABBER_OFF];
            strap_done_reg <= 1'b1;
        end else if (!strap_done_reg) begin
            // crossover strap is caught once after reset release
            swap_reg       <= s_strap;
            strap_done_reg <= 1'b1;
        end
    end

    // page received latch; a new page beats the read clear
    always_ff @(posedge clk) begin
        if (!rstn) begin
            page_reg      <= 1'b0;
            page_prev_reg <= 1'b0;
        end else begin
            page_prev_reg <= s_page;
            if (page_evt) begin
                page_reg <= 1'b1;
            end else if (wr_sts_rd) begin
                page_reg <= 1'b0;
            end
        end
    end

    // control word as read back
    always_comb begin
        ctl_word = {fifo_reg, `CTL_RSVD_HI_VAL, force_reg, psave_reg, deep_reg,
                    swap_reg, clk_off_reg, 1'b1, standby_reg, inv_reg, jab_off_reg};
    end

    // live status word
    always_comb begin
        sts_word        = 16'h0000;
        sts_word[15:14] = (s_rate == 2'b11) ? 2'b00 : s_rate;
        sts_word[13]    = s_fdx;
        sts_word[12]    = page_reg;
        sts_word[11]    = s_an_done | ~s_an_en;
        sts_word[10]    = s_link;
        sts_word[9]     = s_cd;
        sts_word[8]     = s_ab;
        sts_word[7]     = s_an_en & ~s_an_done & s_ds;
        sts_word[6]     = s_sleep | sleeping_reg;
        sts_word[5:2]   = (s_link && s_rate == phy_regs_pkg::RATE_1000) ? s_pol : 4'h0;
        sts_word[1]     = s_pol10;
        sts_word[0]     = s_jab;
    end

    // read data, valid only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            if (addr_hit(reg_addr, `OFS_TRANSCEIVER_CONTROL)) begin
                reg_rdata <= ctl_word;
            end else if (addr_hit(reg_addr, `OFS_LINK_STATUS_SUMMARY)) begin
                reg_rdata <= sts_word;   // bit 0 not cleared by read
            end else begin
                reg_rdata <= 16'h0000;
            end
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // active sleep: partner clears the sleep flag and lifts power-down for one cycle only, periodic link pulse
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sleeping_reg <= 1'b0;
            wake_cnt_reg <= '0;
            wake_pulse   <= 1'b0;
        end else if (psave_reg == phy_regs_pkg::PS_ACTIVE && !s_partner) begin
            sleeping_reg <= 1'b1;
            wake_pulse   <= (wake_cnt_reg == CNT_W'(WAKE_CYCLES - 1));
            wake_cnt_reg <= (wake_cnt_reg == CNT_W'(WAKE_CYCLES - 1)) ? '0 : wake_cnt_reg + 1'b1;
        end else begin
            sleeping_reg <= (psave_reg == phy_regs_pkg::PS_PASSIVE);
            wake_cnt_reg <= '0;
            wake_pulse   <= 1'b0;
        end
    end

    // control outputs to the transceiver core
    always_ff @(posedge clk) begin
        if (!rstn) begin
            gigabit_ref_clock_out_en <= 1'b1;
            pll_power_down           <= 1'b0;
            analog_power_down        <= 1'b0;
            link_block               <= 1'b0;
            tx_invert_enable         <= 1'b0;
            jabber_enable            <= 1'b1;
            pair_swap_select         <= `CTL_SWAP_RST;
            force_link_good          <= 1'b0;
            tx_fifo_depth            <= `CTL_TX_FIFO_RST;
            deep_power_down_en       <= 1'b0;
        end else begin
            gigabit_ref_clock_out_en <= ~clk_off_reg;
            pll_power_down           <= (psave_reg == phy_regs_pkg::PS_IEEE_PD)
                                        & ~clk_off_reg;
            analog_power_down        <= (psave_reg != phy_regs_pkg::PS_NORMAL)
                                        & ~(sleeping_reg & s_partner);
            link_block               <= standby_reg;
            tx_invert_enable         <= inv_reg;
            jabber_enable            <= ~jab_off_reg;
            // 1x auto, 01 mdix, 00 mdi
            pair_swap_select         <= swap_reg[1] ? phy_regs_pkg::SWAP_AUTO : swap_reg;
            force_link_good          <= force_reg;
            tx_fifo_depth            <= fifo_reg;
            deep_power_down_en       <= deep_reg;
        end
    end

endmodule // phy_control_status_regs

`default_nettype wire

// ### verif/phy_control_status_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module phy_ctl_sts_checker (
    input wire logic        clk,                      // device clock
    input wire logic        rstn,                     // sync reset, active low
    input wire logic [4:0]  reg_addr,                 // register index
    input wire logic [15:0] reg_wdata,                // write data
    input wire logic        reg_wr,                   // write strobe
    input wire logic        reg_rd,                   // read strobe
    input wire logic [15:0] reg_rdata,                // read data
    input wire logic        st_link_up,               // raw link state
    input wire logic        gigabit_ref_clock_out_en, // clock output enable
    input wire logic        pll_power_down,           // pll off request
    input wire logic        link_block,               // standby link block
    input wire logic        tx_invert_enable,         // line driver invert
    input wire logic        jabber_enable,            // jabber detection on
    input wire logic [1:0]  pair_swap_select          // crossover mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // control write taken at this edge
    wire logic ctl_wr = reg_wr && (reg_addr == 5'h10);

    property p_swap; ctl_wr |-> ##2 pair_swap_select ==
        ($past(reg_wdata[6], 2) ? 2'b10 : {1'b0, $past(reg_wdata[5], 2)}); endproperty
    a_swap: assert property (p_swap) else $error("crossover mode mismatch");
    property p_clk; ctl_wr |-> ##2 gigabit_ref_clock_out_en == !$past(reg_wdata[4], 2);
    endproperty
    a_clk: assert property (p_clk) else $error("clock enable mismatch");
    property p_rsvd; reg_rd && reg_addr == 5'h10 |=> reg_rdata[3]; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit not one");
    property p_stby; ctl_wr |-> ##2 link_block == $past(reg_wdata[2], 2); endproperty
    a_stby: assert property (p_stby) else $error("standby mismatch");
    property p_inv; ctl_wr |-> ##2 tx_invert_enable == $past(reg_wdata[1], 2); endproperty
    a_inv: assert property (p_inv) else $error("invert mismatch");
    property p_jab; ctl_wr |-> ##2 jabber_enable != $past(reg_wdata[0], 2); endproperty
    a_jab: assert property (p_jab) else $error("jabber enable mismatch");
    property p_pll; ctl_wr |-> ##2 pll_power_down ==
        ($past(reg_wdata[9:8], 2) == 2'b01 && !$past(reg_wdata[4], 2)); endproperty
    a_pll: assert property (p_pll) else $error("pll power mismatch");
    property p_link; (st_link_up == $past(st_link_up))[*5] ##0 (reg_rd && reg_addr == 5'h11)
        |=> reg_rdata[10] == $past(st_link_up); endproperty
    a_link: assert property (p_link) else $error("link bit mismatch");
endmodule // phy_ctl_sts_checker

bind phy_control_status_regs phy_ctl_sts_checker u_chk (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .st_link_up(st_link_up), .pll_power_down(pll_power_down),
    .gigabit_ref_clock_out_en(gigabit_ref_clock_out_en), .link_block(link_block),
    .tx_invert_enable(tx_invert_enable), .jabber_enable(jabber_enable),
    .pair_swap_select(pair_swap_select));

`default_nettype wire

// ### verif/tb_phy_control_status_regs.sv
`timescale 1ns/1ps
`default_nettype none

module tb_phy_control_status_regs;
    logic        clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0; // clock, reset, strobes
    logic [4:0]  reg_addr = 5'h00;                       // register index
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rdv;   // bus data, read result
    logic [1:0]  strap_swap = 2'b01, st_rate = 2'b00;    // strap, resolved rate
    logic        st_full_duplex = 0, st_page_rx = 0, st_an_enable = 0, st_an_done = 0;
    logic        st_link_up = 0, st_cd_swapped = 0, st_ab_swapped = 0, st_downshift = 0;
    logic        st_sleeping = 0, st_pol_10m = 1, st_jabber = 0, partner_seen = 0;
    logic [3:0]  st_chan_pol = 4'h0;                     // gigabit channel polarity
    logic        gigabit_ref_clock_out_en, pll_power_down, analog_power_down, link_block;
    logic        tx_invert_enable, jabber_enable, force_link_good, deep_power_down_en;
    logic        wake_pulse;                              // active sleep pulse
    logic [1:0]  pair_swap_select, tx_fifo_depth;        // crossover mode, fifo depth
    int          n_errors = 0, n_tests = 0;              // mismatch and compare counts
    // control outputs gathered for one compare
    wire logic [11:0] outs = {gigabit_ref_clock_out_en, pll_power_down, analog_power_down,
        link_block, tx_invert_enable, jabber_enable, pair_swap_select, tx_fifo_depth,
        force_link_good, deep_power_down_en};
    // control rows: written word, expected readback
    logic [15:0] ctl_rows [8][2] = '{'{16'h0000, 16'h1008}, '{16'h0020, 16'h1028},
        '{16'h0040, 16'h1048}, '{16'h0060, 16'h1068}, '{16'hFFFF, 16'hD7FF},
        '{16'h0117, 16'h111F}, '{16'h0106, 16'h110E}, '{16'h8200, 16'h9208}};
    // status rows: core state word, expected status readback
    // active sleep is still selected from the last control row, so bit 6 reads one
    logic [15:0] sts_rows [3][2] = '{'{16'hB6A9, 16'hA6E9}, '{16'hC0FE, 16'h0842},
        '{16'h7DBE, 16'h6D42}};

    phy_control_status_regs #(.WAKE_CYCLES(8)) DUT (.clk(clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .strap_swap(strap_swap), .st_rate(st_rate),
        .st_full_duplex(st_full_duplex), .st_page_rx(st_page_rx), .st_an_enable(st_an_enable),
        .st_an_done(st_an_done), .st_link_up(st_link_up), .st_cd_swapped(st_cd_swapped),
        .st_ab_swapped(st_ab_swapped), .st_downshift(st_downshift), .st_sleeping(st_sleeping),
        .st_chan_pol(st_chan_pol), .st_pol_10m(st_pol_10m), .st_jabber(st_jabber),
        .partner_seen(partner_seen), .gigabit_ref_clock_out_en(gigabit_ref_clock_out_en),
        .pll_power_down(pll_power_down), .analog_power_down(analog_power_down),
        .link_block(link_block), .tx_invert_enable(tx_invert_enable),
        .jabber_enable(jabber_enable), .pair_swap_select(pair_swap_select),
        .force_link_good(force_link_good), .tx_fifo_depth(tx_fifo_depth),
        .deep_power_down_en(deep_power_down_en), .wake_pulse(wake_pulse));

    // 25 MHz clock
    always #20 clk = ~clk;

    // compare a read word
    task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: read %h want %h", $time, got, exp);
        end
    endtask
    // compare the control outputs
    task automatic chk_out(input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: outputs %h want %h", $time, got, exp);
        end
    endtask
    // expected control outputs for a written word, partner absent
    function automatic logic [11:0] exp_out(input logic [15:0] d);
        return {~d[4], d[9:8] == 2'b01 && !d[4], d[9:8] != 2'b00, d[2], d[1], ~d[0],
            d[6] ? 2'b10 : {1'b0, d[5]}, d[15:14], d[10], d[7]};
    endfunction
    // one-cycle write strobe
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // one-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // apply core state, then let it pass the sync flops
    task automatic set_st(input logic [15:0] v);
        @(posedge clk);
        {st_rate, st_full_duplex, st_an_enable, st_an_done, st_link_up, st_cd_swapped,
            st_ab_swapped, st_downshift, st_sleeping, st_chan_pol, st_pol_10m, st_jabber} <= v;
        repeat (6) @(posedge clk);
    endtask
    // reset with a strap level, then check defaults
    task automatic do_reset(input logic [1:0] s, input logic [15:0] rb, input logic [11:0] o);
        @(posedge clk);
        rstn <= 1'b0;
        strap_swap <= s;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk_out(outs, o);
        rd(5'h10, rdv);
        chk_rd(rdv, rb);
        $display("reset test done");
    endtask
    // verdict and end of run
    task automatic final_report;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // watchdog on the whole run
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        final_report();
    end

    // main sequence
    initial begin
        do_reset(2'b01, 16'h5028, 12'h854);
        foreach (ctl_rows[i]) begin
            wr(5'h10, ctl_rows[i][0]);
            repeat (2) @(posedge clk);
            #1 chk_out(outs, exp_out(ctl_rows[i][0]));
            rd(5'h10, rdv);
            chk_rd(rdv, ctl_rows[i][1]);
            $display("control row %0d done", i);
        end
        foreach (sts_rows[i]) begin
            set_st(sts_rows[i][0]);
            wr(5'h11, 16'hFFFF);
            rd(5'h11, rdv);
            chk_rd(rdv, sts_rows[i][1]);
            rd(5'h11, rdv);
            chk_rd(rdv, sts_rows[i][1]);
            $display("status row %0d done", i);
        end
        @(posedge clk);
        st_page_rx <= 1'b1;
        @(posedge clk);
        st_page_rx <= 1'b0;
        repeat (4) @(posedge clk);
        rd(5'h11, rdv);
        chk_rd(rdv, 16'h7D42);
        rd(5'h11, rdv);
        chk_rd(rdv, 16'h6D42);
        rd(5'h05, rdv);
        chk_rd(rdv, 16'h0000);
        $display("page and unmapped test done");
        do_reset(2'b00, 16'h5008, 12'h844);
        final_report();
    end
endmodule // tb_phy_control_status_regs

`default_nettype wire
